// ===== ascic_ctrl.sv
`timescale 1ns/1ps

// Function
// - first result waits an initialization period
// - immediate update also waits initialization
// - auto chopper hides settling results
// - enable, decimation, polarity, clock, leaving auto chopper settle
// - current gain change needs settling
// - voltage channel change needs settling
// - settling lasts two conversions
// - clock select applied through sync path
// - pll kept running while selected and a converter is enabled
// - clock change applied 35 ticks early
// - five individually enabled interrupt sources
// - ic, ac and detection interrupts
// - comparator mode keeps completion interrupts
// - other thermistor input switched to ground
// - diagnosis channels for both converters
// - diagnosis pull-up fields drive pin pull-ups
// - sync command code table
// - busy flag while update pending
module ascic_ctrl (
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic                  adc_tick,
   input  wire ascic_pkg::ascic_cfg_t cfg_write,
   input  wire logic [1:0]            sync_command,
   input  wire logic                  sync_command_write,
   input  wire logic [4:0]            irq_enable,
   input  wire logic                  rc_comparator_enable,
   input  wire logic                  rc_detect,
   output logic                       sync_busy_flag,
   output logic [1:0]                 sync_command_state,
   output ascic_pkg::ascic_cfg_t      cfg_applied,
   output logic                       sampling_clock_select,
   output logic                       pll_keep_running,
   output logic                       converter_reset,
   output logic                       v_ic_valid,
   output logic                       v_ac_valid,
   output logic                       c_ic_valid,
   output logic                       c_ac_valid,
   output logic [4:0]                 adc_irq,
   output logic                       thermistor_a_to_ground,
   output logic                       thermistor_b_to_ground,
   output logic                       voltage_diag_select,
   output logic                       current_diag_select,
   output logic [1:0]                 voltage_pin_pullup_diag,
   output logic [1:0]                 current_pin_pullup_diag
);

   // whole state of the controller
   typedef struct packed {
      ascic_pkg::ascic_state_t state;   // sequencer state
      ascic_pkg::ascic_cfg_t   shadow;  // settings held for update
      ascic_pkg::ascic_cfg_t   active;  // settings in use
      logic                    busy;    // update pending
      ascic_pkg::ascic_sync_t  cmd;     // pending command
      logic                    armed;   // edge update committed
      logic [5:0]              init_cnt;
      logic [9:0]              ic_cnt;  // ticks inside an ic
      logic [5:0]              ac_cnt;  // ics inside an ac
      logic [4:0]              irq;     // interrupt pulses
      logic                    clk_sel; // applied sampling clock
      logic                    pll_keep;
      logic                    conv_rst;
      logic                    gnd_a;
      logic                    gnd_b;
      logic                    v_diag;
      logic                    c_diag;
   } ascic_main_t;

   ascic_main_t st;        // registered state
   ascic_main_t next_st;   // next state

   logic [9:0] ic_len;     // ticks per instantaneous conversion
   logic [5:0] ac_ratio;   // instantaneous per accumulated
   logic       ic_last;    // last tick of an instantaneous conversion
   logic       ic_edge;    // instantaneous conversion completes
   logic       ac_edge;    // accumulated conversion completes
   logic       lead_ic;    // lead point ahead of next ic edge
   logic       lead_ac;    // lead point ahead of next ac edge
   logic       both_off;   // both converters disabled now
   logic       apply;      // shadow settings take effect
   logic       v_restart;  // voltage converter must settle
   logic       c_restart;  // current converter must settle

   // conversion lengths follow the active decimation
   assign ic_len   = ascic_pkg::IC_BASE_TICKS << st.active.ic_dec;
   assign ac_ratio = ascic_pkg::AC_BASE_RATIO << st.active.ac_dec;
   // conversion edges, only while running
   assign ic_last = adc_tick && (st.ic_cnt == ic_len - 10'h001);
   assign ic_edge = (st.state == ascic_pkg::ST_RUN) && ic_last;
   assign ac_edge = ic_edge && (st.ac_cnt == ac_ratio - 6'h01);
   // lead point; a command seen later waits one more edge
   assign lead_ic = (st.state == ascic_pkg::ST_RUN) && adc_tick
                    && (st.ic_cnt == ic_len - 10'h001
                        - ascic_pkg::CLK_LEAD_TICKS);
   assign lead_ac = lead_ic && (st.ac_cnt == ac_ratio - 6'h01);
   assign both_off = !st.active.v_en && !st.active.c_en;
   // when the pending update lands
   always_comb begin
      apply = 1'b0;
      if (st.busy) begin
         unique case (st.cmd)
            ascic_pkg::SYNC_RESET: apply = 1'b1;
            ascic_pkg::SYNC_IC:    apply = both_off || (st.armed && ic_edge);
            ascic_pkg::SYNC_AC:    apply = both_off || (st.armed && ac_edge);
            default:               apply = 1'b0;  // not reachable busy
         endcase
      end
   end

   // settling-relevant differences between old and new settings
   always_comb begin
      logic common;   // changes that hit both converters
      logic leave;    // leaving automatic chopper
      leave = (st.active.chop == ascic_pkg::CHOP_FAST
               || st.active.chop == ascic_pkg::CHOP_SLOW)
              && st.shadow.chop != st.active.chop;
      // dec, polarity and clock changes, leaving auto chopper, reset command
      common = (st.shadow.ic_dec != st.active.ic_dec)
               || (st.shadow.ac_dec != st.active.ac_dec)
               || (st.shadow.pol_sel != st.active.pol_sel)
               || (st.shadow.clk_sel != st.active.clk_sel)
               || leave
               || (st.cmd == ascic_pkg::SYNC_RESET);
      // enabling, plus channel change for voltage
      v_restart = apply && st.shadow.v_en
                  && (!st.active.v_en || common
                      || st.shadow.v_chan != st.active.v_chan);
      // enabling, plus gain or diagnosis channel change for current
      c_restart = apply && st.shadow.c_en
                  && (!st.active.c_en || common
                      || st.shadow.c_gain != st.active.c_gain
                      || st.shadow.c_diag != st.active.c_diag);
   end

   // sequencer, sync path and derived outputs
   always_comb begin
      next_st = st;
      next_st.conv_rst = 1'b0;
      next_st.irq = '0;
      // command taken only while idle and not a no-op
      if (sync_command_write && !st.busy
          && sync_command != ascic_pkg::SYNC_NONE) begin
         next_st.busy = 1'b1;
         next_st.cmd = ascic_pkg::ascic_sync_t'(sync_command);
         next_st.shadow = cfg_write;   // buffers locked while busy
      end

      // commit an edge update at the lead point
      if (st.busy && !st.armed
          && ((st.cmd == ascic_pkg::SYNC_IC && lead_ic)
              || (st.cmd == ascic_pkg::SYNC_AC && lead_ac))) begin
         next_st.armed = 1'b1;
         next_st.clk_sel = st.shadow.clk_sel;  // ongoing one stretches
      end

      // sequencer counters
      unique case (st.state)
         ascic_pkg::ST_OFF: begin
            next_st.ic_cnt = '0;
            next_st.ac_cnt = '0;
         end
         ascic_pkg::ST_INIT: begin
            // extra start-up period before conversions run
            if (adc_tick) begin
               if (st.init_cnt == ascic_pkg::INIT_TICKS - 6'h01) begin
                  next_st.state = ascic_pkg::ST_RUN;
               end else begin
                  next_st.init_cnt = st.init_cnt + 6'h01;
               end
            end
         end
         ascic_pkg::ST_RUN: begin
            if (ic_last) begin
               next_st.ic_cnt = '0;
               next_st.ac_cnt = ac_edge ? 6'h00 : st.ac_cnt + 6'h01;
            end else if (adc_tick) begin
               next_st.ic_cnt = st.ic_cnt + 10'h001;
            end
         end
         default: begin
            next_st.state = ascic_pkg::ST_OFF;  // illegal code recovers
         end
      endcase
      // update lands; busy and command clear together
      if (apply) begin
         next_st.active = st.shadow;
         next_st.clk_sel = st.shadow.clk_sel;
         next_st.busy = 1'b0;
         next_st.cmd = ascic_pkg::SYNC_NONE;
         next_st.armed = 1'b0;
         if (!st.shadow.v_en && !st.shadow.c_en) begin
            next_st.state = ascic_pkg::ST_OFF;
         end else if (st.cmd == ascic_pkg::SYNC_RESET || both_off) begin
            // same start-up wait as from fully off
            next_st.state = ascic_pkg::ST_INIT;
            next_st.init_cnt = '0;
            next_st.ic_cnt = '0;
            next_st.ac_cnt = '0;
            next_st.conv_rst = (st.cmd == ascic_pkg::SYNC_RESET);
         end
      end
      // five sources, each gated by its own enable
      next_st.irq[ascic_pkg::IRQ_V_IC] = v_ic_valid
                                         && irq_enable[ascic_pkg::IRQ_V_IC];
      next_st.irq[ascic_pkg::IRQ_V_AC] = v_ac_valid
                                         && irq_enable[ascic_pkg::IRQ_V_AC];
      // comparator mode does not mask completions
      next_st.irq[ascic_pkg::IRQ_C_IC] = c_ic_valid
                                         && irq_enable[ascic_pkg::IRQ_C_IC];
      next_st.irq[ascic_pkg::IRQ_C_AC] = c_ac_valid
                                         && irq_enable[ascic_pkg::IRQ_C_AC];
      next_st.irq[ascic_pkg::IRQ_C_RCD] = rc_detect && rc_comparator_enable
                                          && st.active.c_en
                                          && irq_enable[ascic_pkg::IRQ_C_RCD];

      // pll held on while it clocks an enabled converter
      next_st.pll_keep = (next_st.clk_sel == ascic_pkg::CLK_PLL)
                         && (next_st.active.v_en || next_st.active.c_en);

      // shared divider: ground the thermistor not measured
      next_st.gnd_a = next_st.active.v_en && next_st.active.therm_shared
                      && next_st.active.v_chan == ascic_pkg::VCH_THERM_B;
      next_st.gnd_b = next_st.active.v_en && next_st.active.therm_shared
                      && next_st.active.v_chan == ascic_pkg::VCH_THERM_A;
      // diagnosis inputs
      next_st.v_diag = next_st.active.v_en
                       && next_st.active.v_chan == ascic_pkg::VCH_DIAG;
      next_st.c_diag = next_st.active.c_en && next_st.active.c_diag;
   end

   // state register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '{state: ascic_pkg::ST_OFF,
                 shadow: ascic_pkg::CFG_RESET,
                 active: ascic_pkg::CFG_RESET,
                 cmd: ascic_pkg::SYNC_NONE,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   // voltage converter result qualifier
   ascic_settle u_v_settle (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .restart   (v_restart),
      .auto_mode (st.shadow.chop == ascic_pkg::CHOP_FAST
                  || st.shadow.chop == ascic_pkg::CHOP_SLOW),
      .enabled   (st.active.v_en),
      .ic_edge   (ic_edge),
      .ac_edge   (ac_edge),
      .ic_valid  (v_ic_valid),
      .ac_valid  (v_ac_valid)
   );

   // current converter result qualifier
   ascic_settle u_c_settle (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .restart   (c_restart),
      .auto_mode (st.shadow.chop == ascic_pkg::CHOP_FAST
                  || st.shadow.chop == ascic_pkg::CHOP_SLOW),
      .enabled   (st.active.c_en),
      .ic_edge   (ic_edge),
      .ac_edge   (ac_edge),
      .ic_valid  (c_ic_valid),
      .ac_valid  (c_ac_valid)
   );

   // outputs, all from flip-flops
   assign sync_busy_flag          = st.busy;
   assign sync_command_state      = st.cmd;
   assign cfg_applied             = st.active;
   assign sampling_clock_select   = st.clk_sel;
   assign pll_keep_running        = st.pll_keep;
   assign converter_reset         = st.conv_rst;
   assign adc_irq                 = st.irq;
   assign thermistor_a_to_ground  = st.gnd_a;
   assign thermistor_b_to_ground  = st.gnd_b;
   assign voltage_diag_select     = st.v_diag;
   assign current_diag_select     = st.c_diag;
   // pull-ups follow the applied diagnosis fields
   assign voltage_pin_pullup_diag = st.active.v_pullup;
   assign current_pin_pullup_diag = st.active.c_pullup;

   // running only after a full initialization count
   property p_init_len;
      @(posedge mclk) disable iff (sys_rst)
      $rose(st.state == ascic_pkg::ST_RUN)
         |-> $past(st.init_cnt) == 6'h22;
   endproperty
   a_init_len: assert property (p_init_len)
      else $error("run entered before init period");
   // immediate command resets and restarts initialization
   property p_reset_cmd;
      @(posedge mclk) disable iff (sys_rst)
      (st.busy && st.cmd == ascic_pkg::SYNC_RESET
       && (st.shadow.v_en || st.shadow.c_en))
         |=> (st.state == ascic_pkg::ST_INIT && converter_reset
              && !sync_busy_flag);
   endproperty
   a_reset_cmd: assert property (p_reset_cmd)
      else $error("immediate update skipped init");
   // an accepted write shows busy and the command
   sequence s_cmd_taken;
      sync_command_write && !sync_busy_flag && sync_command != 2'h0;
   endsequence
   property p_cmd_taken;
      @(posedge mclk) disable iff (sys_rst)
      s_cmd_taken |=> (sync_busy_flag
                       && sync_command_state == $past(sync_command));
   endproperty
   a_cmd_taken: assert property (p_cmd_taken)
      else $error("sync command not taken");
   // busy falls only when the shadow lands
   property p_busy_fall;
      @(posedge mclk) disable iff (sys_rst)
      $fell(sync_busy_flag)
         |-> (cfg_applied == $past(st.shadow)
              && sync_command_state == 2'h0);
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy cleared without update");
   // arming switches the clock to the new choice
   property p_clk_lead;
      @(posedge mclk) disable iff (sys_rst)
      $rose(st.armed) |-> (sampling_clock_select == st.shadow.clk_sel
                           && $past(st.ic_cnt) == ic_len - 10'h024);
   endproperty
   a_clk_lead: assert property (p_clk_lead)
      else $error("clock change not at lead point");
   // pll kept on while selected and converting
   property p_pll_keep;
      @(posedge mclk) disable iff (sys_rst)
      (cfg_applied.v_en && sampling_clock_select == 1'b0)
         |-> pll_keep_running;
   endproperty
   a_pll_keep: assert property (p_pll_keep)
      else $error("pll released while in use");
   // interrupts only with their own enable set
   property p_irq_gate;
      @(posedge mclk) disable iff (sys_rst)
      (adc_irq != 5'h00) |-> ((adc_irq & ~$past(irq_enable)) == 5'h00);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("masked interrupt raised");
   // measuring input a grounds input b
   property p_therm_gnd;
      @(posedge mclk) disable iff (sys_rst)
      (cfg_applied.v_en && cfg_applied.therm_shared
       && cfg_applied.v_chan == 3'h0)
         |-> (thermistor_b_to_ground && !thermistor_a_to_ground);
   endproperty
   a_therm_gnd: assert property (p_therm_gnd)
      else $error("thermistor ground not switched");

endmodule : ascic_ctrl

// ===== ascic_pkg.sv
package ascic_pkg;

   // synchronization command codes
   typedef enum logic [1:0] {
      SYNC_NONE  = 2'h0,   // no action
      SYNC_RESET = 2'h1,   // reset the converters and update now
      SYNC_IC    = 2'h2,   // update at next instantaneous edge
      SYNC_AC    = 2'h3    // update at next accumulated edge
   } ascic_sync_t;

   // chopper modes
   typedef enum logic [1:0] {
      CHOP_OFF  = 2'h0,
      CHOP_FAST = 2'h1,
      CHOP_SLOW = 2'h2,
      CHOP_SW   = 2'h3
   } ascic_chop_t;

   // main sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_OFF  = 3'h1,      // both converters disabled
      ST_INIT = 3'h2,      // start-up initialization
      ST_RUN  = 3'h4       // converting
   } ascic_state_t;

   // sampling clock select codes
   localparam logic CLK_PLL = 1'h0;   // 512 kHz pll
   localparam logic CLK_RC  = 1'h1;   // 128 kHz slow rc

   // timing, in converter clock ticks
   localparam logic [5:0] INIT_TICKS     = 6'h23;   // 35, inside 30..40
   localparam logic [9:0] CLK_LEAD_TICKS = 10'h023; // 35 before edge
   localparam logic [1:0] SETTLE_CONV    = 2'h2;    // settling results
   localparam logic [9:0] IC_BASE_TICKS  = 10'h040; // ic length, dec 0
   localparam logic [5:0] AC_BASE_RATIO  = 6'h04;   // ics per ac, dec 0

   // voltage converter channel codes
   localparam logic [2:0] VCH_THERM_A = 3'h0;
   localparam logic [2:0] VCH_THERM_B = 3'h1;
   localparam logic [2:0] VCH_DIAG    = 3'h6;       // half reference

   // interrupt source positions
   localparam int IRQ_V_IC  = 0;
   localparam int IRQ_V_AC  = 1;
   localparam int IRQ_C_IC  = 2;
   localparam int IRQ_C_AC  = 3;
   localparam int IRQ_C_RCD = 4;
   localparam int IRQ_COUNT = 5;

   // converter configuration as written by software
   typedef struct packed {
      logic        v_en;      // voltage_converter_enable
      logic        c_en;      // current_converter_enable
      ascic_chop_t chop;      // chopper mode
      logic        pol_sel;   // software chopper polarity
      logic        clk_sel;   // sampling_clock_select
      logic [1:0]  ic_dec;    // instantaneous decimation
      logic [1:0]  ac_dec;    // accumulated decimation
      logic [1:0]  c_gain;    // current input gain
      logic        c_diag;    // current diagnosis channel
      logic [2:0]  v_chan;    // voltage channel
      logic        therm_shared; // shared divider thermistors
      logic [1:0]  v_pullup;  // voltage_pin_pullup_diag
      logic [1:0]  c_pullup;  // current_pin_pullup_diag
   } ascic_cfg_t;

   localparam ascic_cfg_t CFG_RESET = '0;

endpackage : ascic_pkg

// ===== ascic_settle.sv
`timescale 1ns/1ps

// result qualifier for one converter: hides the settling results
module ascic_settle (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic restart,    // settling-relevant change applied
   input  wire logic auto_mode,  // automatic fast or slow chopper
   input  wire logic enabled,    // converter enabled
   input  wire logic ic_edge,    // instantaneous conversion edge
   input  wire logic ac_edge,    // accumulated conversion edge
   output logic      ic_valid,   // instantaneous result valid pulse
   output logic      ac_valid    // accumulated result valid pulse
);

   // whole state of the qualifier
   typedef struct packed {
      logic [1:0] ic_skip;
      logic [1:0] ac_skip;
      logic       ic_valid;
      logic       ac_valid;
   } ascic_settle_t;

   ascic_settle_t st;       // registered state
   ascic_settle_t next_st;  // next state

   // skip counts load on restart, decrement on each edge
   always_comb begin
      next_st = st;
      next_st.ic_valid = 1'b0;
      next_st.ac_valid = 1'b0;
      if (restart) begin
         // only automatic modes settle in hardware
         next_st.ic_skip = auto_mode ? ascic_pkg::SETTLE_CONV : 2'h0;
         next_st.ac_skip = auto_mode ? ascic_pkg::SETTLE_CONV : 2'h0;
      end else begin
         if (ic_edge) begin
            if (st.ic_skip != 2'h0) begin
               next_st.ic_skip = st.ic_skip - 2'h1; // discarded
            end else begin
               next_st.ic_valid = enabled;
            end
         end
         if (ac_edge) begin
            if (st.ac_skip != 2'h0) begin
               next_st.ac_skip = st.ac_skip - 2'h1; // discarded
            end else begin
               next_st.ac_valid = enabled;
            end
         end
      end
   end

   // state register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ic_valid = st.ic_valid;
   assign ac_valid = st.ac_valid;

   // a settling edge never yields a valid result
   property p_settle_hide;
      @(posedge mclk) disable iff (sys_rst)
      (ic_edge && !restart && st.ic_skip != 2'h0) |=> !ic_valid;
   endproperty
   a_settle_hide: assert property (p_settle_hide)
      else $error("settling result shown as valid");

   // automatic mode loads two settling conversions
   property p_settle_count;
      @(posedge mclk) disable iff (sys_rst)
      (restart && auto_mode) |=> (st.ic_skip == 2'h2 && st.ac_skip == 2'h2);
   endproperty
   a_settle_count: assert property (p_settle_count)
      else $error("settling count not two");

endmodule : ascic_settle

// ===== ascic_ctrl_tb.sv
`timescale 1ns/1ps

// bench for the converter control block, driven on the falling edge
module ascic_ctrl_tb;
   logic                  mclk, sys_rst, sync_command_write;
   logic                  adc_tick = 1'h0;  // known before the first edge
   logic                  rc_comparator_enable, rc_detect, sync_busy_flag;
   logic                  sampling_clock_select, pll_keep_running;
   logic                  converter_reset, v_ic_valid, v_ac_valid;
   logic                  c_ic_valid, c_ac_valid, thermistor_a_to_ground;
   logic                  thermistor_b_to_ground, voltage_diag_select;
   logic                  current_diag_select;
   logic [1:0]            sync_command, sync_command_state;
   logic [1:0]            voltage_pin_pullup_diag, current_pin_pullup_diag;
   logic [4:0]            irq_enable, adc_irq;
   ascic_pkg::ascic_cfg_t cfg_write, cfg_applied, c;
   int                    n_fail = 0;
   int                    n_compared = 0;
   int                    n, i;
   // settings beside the pin levels they should give
   typedef struct packed {
      ascic_pkg::ascic_cfg_t cfg;
      logic [7:0]            pins;
   } ascic_row_t;
   ascic_row_t            rows [4];

   ascic_ctrl dut_u (.mclk, .sys_rst, .adc_tick, .cfg_write, .sync_command,
      .sync_command_write, .irq_enable, .rc_comparator_enable, .rc_detect,
      .sync_busy_flag, .sync_command_state, .cfg_applied,
      .sampling_clock_select, .pll_keep_running, .converter_reset,
      .v_ic_valid, .v_ac_valid, .c_ic_valid, .c_ac_valid, .adc_irq,
      .thermistor_a_to_ground, .thermistor_b_to_ground, .voltage_diag_select,
      .current_diag_select, .voltage_pin_pullup_diag, .current_pin_pullup_diag);

   // 50 ns clock
   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end

   // converter tick every second clock, far slower would only lengthen runs
   always @(negedge mclk) begin
      adc_tick <= ~adc_tick;
   end

   // both converters on, channel and pin fields from f
   function automatic ascic_pkg::ascic_cfg_t mk(input logic [2:0] ch,
         input logic [5:0] f);
      ascic_pkg::ascic_cfg_t m;
      m = ascic_pkg::CFG_RESET;
      m.v_en = 1'h1;
      m.c_en = 1'h1;
      m.v_chan = ch;
      {m.therm_shared, m.c_diag, m.v_pullup, m.c_pullup} = f;
      return m;
   endfunction : mk

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // one write pulse, entered and left at a falling edge
   task automatic send(input ascic_pkg::ascic_cfg_t cf, input logic [1:0] cd);
      cfg_write = cf;
      sync_command = cd;
      sync_command_write = 1'h1;
      @(negedge mclk);
      sync_command_write = 1'h0;
   endtask : send

   // ticks until the next voltage ic valid; a hang ends the run
   task automatic ticks_to_valid(output int cnt);
      cnt = 0;
      for (int k = 0; k < 4000 && v_ic_valid !== 1'h1; k++) begin
         if (adc_tick) cnt++;
         @(negedge mclk);
      end
      if (v_ic_valid !== 1'h1) begin
         n_fail++;
         finish_test();
      end
   endtask : ticks_to_valid

   initial begin
      {sys_rst, sync_command_write, rc_comparator_enable} = 3'h4;
      {rc_detect, sync_command, irq_enable} = 8'h00;
      cfg_write = ascic_pkg::CFG_RESET;
      rows = '{'{mk(ascic_pkg::VCH_THERM_A, 6'h26), 8'h46},
               '{mk(ascic_pkg::VCH_THERM_B, 6'h29), 8'h89},
               '{mk(ascic_pkg::VCH_THERM_A, 6'h1F), 8'h1F},
               '{mk(ascic_pkg::VCH_DIAG, 6'h20), 8'h20}};
      repeat (20) @(negedge mclk);
      chk({sync_busy_flag, converter_reset, adc_irq}, 10'h000);
      sys_rst = 1'h0;
      @(negedge mclk);
      // immediate update per row: busy, reset pulse, then pin levels
      foreach (rows[r]) begin
         send(rows[r].cfg, 2'h1);
         chk({sync_busy_flag, sync_command_state}, 10'h005);
         @(negedge mclk);
         chk({sync_busy_flag, converter_reset}, 10'h001);
         repeat (2) @(negedge mclk);
         chk({thermistor_a_to_ground, thermistor_b_to_ground,
            voltage_diag_select, current_diag_select, voltage_pin_pullup_diag,
            current_pin_pullup_diag}, {2'h0, rows[r].pins});
      end
      // no chopper: first result after init plus one ic, irq masked
      c = mk(ascic_pkg::VCH_THERM_A, 6'h00);
      send(c, 2'h1);
      @(negedge mclk);
      ticks_to_valid(n);
      chk({9'h0, n >= 94 && n <= 105}, 10'h001);
      @(negedge mclk);
      chk({5'h0, adc_irq}, 10'h000);
      // auto fast chopper: two settling ics hidden, irq enabled
      c.chop = ascic_pkg::CHOP_FAST;
      irq_enable = 5'h01;
      send(c, 2'h1);
      @(negedge mclk);
      ticks_to_valid(n);
      chk({9'h0, n >= 222 && n <= 233}, 10'h001);
      chk({7'h0, v_ac_valid, c_ic_valid, c_ac_valid}, 10'h002);
      @(negedge mclk);
      chk({5'h0, adc_irq}, 10'h001);
      chk({9'h0, pll_keep_running}, 10'h001);
      // clock switch at next ic; a second write while busy is ignored
      c.clk_sel = ascic_pkg::CLK_RC;
      send(c, 2'h2);
      @(negedge mclk);
      send(mk(ascic_pkg::VCH_THERM_B, 6'h00), 2'h3);
      chk({sync_busy_flag, sync_command_state}, 10'h006);
      n = 0;
      for (i = 0; i < 3000 && sync_busy_flag === 1'h1; i++) begin
         if (adc_tick && sampling_clock_select) n++;
         @(negedge mclk);
      end
      chk({sync_busy_flag, n >= 30 && n <= 40}, 10'h001);
      chk({cfg_applied.v_chan, sampling_clock_select, pll_keep_running},
         10'h002);
      // detection irq follows the comparator enable
      irq_enable = 5'h10;
      for (i = 1; i >= 0; i--) begin
         rc_comparator_enable = i[0];
         rc_detect = 1'h1;
         n = 0;
         repeat (3) begin
            @(negedge mclk);
            rc_detect = 1'h0;
            n = n | adc_irq[4];
         end
         chk(n[9:0], i[9:0]);
      end
      // slow chopper back on the pll: settling hidden, pll held on
      c.chop = ascic_pkg::CHOP_SLOW;
      c.clk_sel = ascic_pkg::CLK_PLL;
      send(c, 2'h1);
      @(negedge mclk);
      ticks_to_valid(n);
      chk({9'h0, n >= 222 && n <= 233}, 10'h001);
      chk({8'h0, sampling_clock_select, pll_keep_running}, 10'h001);
      finish_test();
   end
endmodule : ascic_ctrl_tb
